/* logic/src_system_control.sv */
// System reset, reset cause, watchdog and clock selection control
`timescale 1ns/100ps
`default_nettype none
module src_system_control
(
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        ext_rst_n_i,
   input  wire logic                        brownout_i,
   input  wire logic [src_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [src_pkg::DATA_W-1:0]  wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic      [src_pkg::DATA_W-1:0]  rdata_o,
   output logic                             sys_rst_n_o,
   output logic                             tap_rst_n_o,
   output logic      [src_pkg::PER_W-1:0]   per_rst_n_o,
   output logic      [src_pkg::PER_W-1:0]   per_clk_en_o,
   output logic                             brownout_irq_o,
   output logic                             wdt_irq_o,
   output logic      [2:0]                  clk_src_o,
   output logic      [5:0]                  sys_div_o,
   output logic      [5:0]                  regulator_adjust_o,
   output logic      [2:0]                  deep_sleep_src_o,
   output logic                             adc_clk_en_o
);
   import src_pkg::*;

   logic        ext_s1_q, ext_s2_q, bor_s1_q, bor_s2_q;
   logic [31:0] bor_ctl_q, rcc_q, rcc_ext_q, wdt_load_q, wdt_cnt_q, wdt_ctl_q;
   logic [31:0] srst_q [3];
   logic [31:0] cgate_q [3];
   logic [4:0]  cause_q;
   logic        wdt_int_q, wdt_rst_req_q, sw_req_q, por_done_q, bor_hold_q;
   logic [5:0]  regulator_adjust_q;
   logic [2:0]  dslp_q;
   logic [15:0] adc_acc_q;
   logic [7:0]  hold_cnt_q;
   logic        sys_rst_n_q;
   logic [PER_W-1:0] srst_prev_q, per_pulse_q;
   logic [31:0] rdata_q;
   logic        bor_rst, rst_src, soft_rst;
   logic [31:0] rcc_eff;
   src_rst_state_t st_q;

   // Two-flop synchronisers for pin-level sources
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         bor_s1_q <= 1'b0;
         bor_s2_q <= 1'b0;
      end
      else
      begin
         ext_s1_q <= ~ext_rst_n_i;
         ext_s2_q <= ext_s1_q;
         bor_s1_q <= brownout_i;
         bor_s2_q <= bor_s1_q;
      end

   assign bor_rst  = bor_s2_q && bor_ctl_q[BOR_RST_EN_BIT];      // [R3]
   assign rst_src  = ext_s2_q || bor_rst || bor_hold_q || wdt_rst_req_q || sw_req_q; // [R26] [R4]
   assign soft_rst = !sys_rst_n_q;

   // Brownout reset latched until supply recovers; survives the config clear
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
         bor_hold_q <= 1'b0;
      else
         bor_hold_q <= bor_s2_q && (bor_hold_q || bor_rst);              // [R4]

   // Internal reset sequencer: hold while any source active, then release
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         st_q        <= SRC_HOLD;
         hold_cnt_q  <= 8'h00;
         sys_rst_n_q <= 1'b0;
      end
      else
         unique case (st_q)
            SRC_RUN:
               if (rst_src)
               begin
                  st_q        <= SRC_HOLD;                         // [R10] [R14]
                  sys_rst_n_q <= 1'b0;                             // [R9]
                  hold_cnt_q  <= 8'h00;
               end
            SRC_HOLD:
               if (rst_src)
                  hold_cnt_q <= 8'h00;                            // [R4]
               else if (hold_cnt_q == 8'(RST_HOLD_CYC - 1))
                  st_q <= SRC_RELEASE;
               else
                  hold_cnt_q <= hold_cnt_q + 8'h01;
            SRC_RELEASE:
            begin
               sys_rst_n_q <= 1'b1;                                // [R10] [R14]
               st_q        <= SRC_RUN;
            end
         endcase

   assign sys_rst_n_o = sys_rst_n_q;
   assign tap_rst_n_o = por_done_q;                                // [R25]

   // Reset cause, sticky; power-on leaves only its own bit
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         cause_q    <= CAUSE_POR_VAL;                              // [R24]
         por_done_q <= 1'b0;
      end
      else
      begin
         por_done_q <= 1'b1;
         if (wr_i && addr_i == OFS_CAUSE)
            cause_q <= wdata_i[4:0];
         if (ext_s2_q)
            cause_q[CAUSE_EXT_BIT] <= 1'b1;
         if (bor_rst)
            cause_q[CAUSE_BOR_BIT] <= 1'b1;                        // [R5]
         if (wdt_rst_req_q)
            cause_q[CAUSE_WDT_BIT] <= 1'b1;
         if (sw_req_q)
            cause_q[CAUSE_SW_BIT] <= 1'b1;
      end

   // Configuration registers, cleared by the internal system reset too, except regulator adjust and deep-sleep config
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         bor_ctl_q  <= BOR_CTL_RST;                                // [R1]
         rcc_q      <= RCC_RST;                                    // [R16]
         rcc_ext_q  <= RCC_RST;
         wdt_load_q <= WDT_LOAD_RST;
         wdt_ctl_q  <= 32'h0000_0000;
         regulator_adjust_q     <= REGULATOR_ADJUST_RST;
         dslp_q     <= 3'h0;
         sw_req_q   <= 1'b0;
         for (int i = 0; i < 3; i++)
         begin
            srst_q[i]  <= 32'h0000_0000;
            cgate_q[i] <= 32'h0000_0000;
         end
      end
      else if (soft_rst)
      begin
         bor_ctl_q  <= BOR_CTL_RST;
         rcc_q      <= RCC_RST;
         rcc_ext_q  <= RCC_RST;
         wdt_load_q <= WDT_LOAD_RST;
         wdt_ctl_q  <= 32'h0000_0000;
         sw_req_q   <= 1'b0;
         for (int i = 0; i < 3; i++)
         begin
            srst_q[i]  <= 32'h0000_0000;
            cgate_q[i] <= 32'h0000_0000;
         end
      end
      else
      begin
         sw_req_q <= wr_i && addr_i == OFS_SYS_CTL && wdata_i[SYS_RST_REQ_BIT]; // [R9]
         if (wr_i)
            unique case (addr_i)
               OFS_BOR_CTL:  bor_ctl_q  <= wdata_i;
               OFS_SRST0:    srst_q[0]  <= wdata_i;                // [R6]
               OFS_SRST1:    srst_q[1]  <= wdata_i;
               OFS_SRST2:    srst_q[2]  <= wdata_i;
               OFS_CLKGATE0: cgate_q[0] <= wdata_i;                // [R22]
               OFS_CLKGATE1: cgate_q[1] <= wdata_i;
               OFS_CLKGATE2: cgate_q[2] <= wdata_i;
               OFS_RCC:      rcc_q      <= wdata_i;
               OFS_RCC_EXT:  rcc_ext_q  <= wdata_i;
               OFS_REG_CTL:  regulator_adjust_q     <= wdata_i[REGULATOR_ADJUST_W-1:0];   // [R15]
               OFS_WDT_LOAD: wdt_load_q <= wdata_i;
               OFS_WDT_CTL:  wdt_ctl_q  <= {wdata_i[31:3], 1'b0, wdata_i[1:0]};
               OFS_DSLP_CFG: dslp_q     <= wdata_i[2:0];          // [R23]
               default: ;
            endcase
      end

   // Peripheral reset pulse on falling soft-reset bit; one pulse bit per peripheral
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         srst_prev_q <= '0;
         per_pulse_q <= '0;
      end
      else
      begin
         srst_prev_q <= {srst_q[2], srst_q[1], srst_q[0]};
         per_pulse_q <= srst_prev_q & ~{srst_q[2], srst_q[1], srst_q[0]}; // [R6]
      end

   assign per_rst_n_o  = ~(per_pulse_q | {PER_W{soft_rst}});       // [R8] [R7]
   assign per_clk_en_o = {cgate_q[2], cgate_q[1], cgate_q[0]};     // [R7] [R22]

   // Watchdog: first zero interrupts and reloads, second zero resets
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         wdt_cnt_q     <= WDT_LOAD_RST;
         wdt_int_q     <= 1'b0;
         wdt_rst_req_q <= 1'b0;
      end
      else if (soft_rst)
      begin
         wdt_cnt_q     <= WDT_LOAD_RST;
         wdt_int_q     <= 1'b0;
         wdt_rst_req_q <= 1'b0;
      end
      else if (wr_i && addr_i == OFS_WDT_LOAD)
         wdt_cnt_q <= wdata_i;
      else if (wdt_ctl_q[WDT_INT_EN_BIT])
      begin
         if (wdt_cnt_q == 32'h0000_0000)
         begin
            wdt_cnt_q <= wdt_load_q;                               // [R12]
            if (wdt_int_q && wdt_ctl_q[WDT_RST_EN_BIT])
               wdt_rst_req_q <= 1'b1;                              // [R13]
            wdt_int_q <= 1'b1;                                     // [R11]
         end
         else
         begin
            wdt_cnt_q <= wdt_cnt_q - 32'h0000_0001;
            if (wr_i && addr_i == OFS_WDT_CTL && wdata_i[WDT_INT_CLR_BIT])
               wdt_int_q <= 1'b0;
         end
      end

   assign wdt_irq_o      = wdt_int_q;                              // [R11]
   assign brownout_irq_o = bor_s2_q && bor_ctl_q[BOR_INT_BIT] && !bor_ctl_q[BOR_RST_EN_BIT]; // [R2]

   // Clock selection with extended override
   assign rcc_eff   = rcc_ext_q[RCC_EXT_SEL_BIT] ? rcc_ext_q : rcc_q; // [R20]
   assign clk_src_o = (rcc_eff[RCC_SRC_LSB +: 3] > 3'(SRC_INT_DIV4))
                      ? 3'(SRC_INT_OSC) : rcc_eff[RCC_SRC_LSB +: 3]; // [R18]
   assign sys_div_o          = rcc_eff[RCC_DIV_LSB +: 4] == 4'h0 ? 6'h00 : {2'b00, rcc_eff[RCC_DIV_LSB +: 4]};
   assign regulator_adjust_o = regulator_adjust_q;
   assign deep_sleep_src_o   = dslp_q;                             // [R23]

   // Converter clock enable: fractional divide to 16 MHz
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         adc_acc_q    <= 16'h0000;
         adc_clk_en_o <= 1'b0;
      end
      else if (adc_acc_q + 16'(ADC_DIV_STEP) >= 16'(CLK_KHZ))
      begin
         adc_acc_q    <= adc_acc_q + 16'(ADC_DIV_STEP) - 16'(CLK_KHZ); // [R21]
         adc_clk_en_o <= 1'b1;
      end
      else
      begin
         adc_acc_q    <= adc_acc_q + 16'(ADC_DIV_STEP);
         adc_clk_en_o <= 1'b0;
      end

   // Read port, data one cycle after strobe
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i)
         rdata_q <= 32'h0000_0000;
      else if (rd_i)
         unique case (addr_i)
            OFS_BOR_CTL:  rdata_q <= bor_ctl_q;
            OFS_CAUSE:    rdata_q <= {27'h0, cause_q};
            OFS_SRST0:    rdata_q <= srst_q[0];
            OFS_SRST1:    rdata_q <= srst_q[1];
            OFS_SRST2:    rdata_q <= srst_q[2];
            OFS_CLKGATE0: rdata_q <= cgate_q[0];
            OFS_CLKGATE1: rdata_q <= cgate_q[1];
            OFS_CLKGATE2: rdata_q <= cgate_q[2];
            OFS_RCC:      rdata_q <= rcc_q;
            OFS_RCC_EXT:  rdata_q <= rcc_ext_q;
            OFS_REG_CTL:  rdata_q <= {26'h0, regulator_adjust_q};
            OFS_WDT_LOAD: rdata_q <= wdt_load_q;
            OFS_WDT_CTL:  rdata_q <= {wdt_ctl_q[31:3], wdt_int_q, wdt_ctl_q[1:0]};
            OFS_WDT_VAL:  rdata_q <= wdt_cnt_q;
            OFS_DSLP_CFG: rdata_q <= {29'h0, dslp_q};
            default:      rdata_q <= 32'h0000_0000;
         endcase
      else
         rdata_q <= 32'h0000_0000;

   assign rdata_o = rdata_q;
endmodule : src_system_control
`default_nettype wire

/* pkg/src_pkg.sv */
// Constants, register map and types for the system reset and clock control block
//
// What this block does
// [R1] Brown-out reset disabled after reset until enabled
// [R2] Brown-out raises interrupt or reset by configuration
// [R3] Brown-out resets only when its enable set
// [R4] Brown-out reset held while supply low
// [R5] Reset cause records brown-out resets
// [R6] Set then clear soft bit resets peripheral
// [R7] Soft reset bits match clock gate bits
// [R8] Soft reset asserts all unit clock-domain resets
// [R9] System reset request resets whole system
// [R10] Software reset asserts then releases internal reset
// [R11] Watchdog interrupts first, may reset second
// [R12] Watchdog reloads 32-bit counter after first timeout
// [R13] Watchdog resets on second zero if uncleared, enabled
// [R14] Watchdog reset asserts then releases internal reset
// [R15] Regulator adjust spans 2.25 V to 2.75 V
// [R16] Internal oscillator selected during and after power-on
// [R17] Software enables, waits main oscillator before switching
// [R18] Clock mux chooses among six sources
// [R19] Software keeps PLL reference 3.579545-8.192 MHz
// [R20] Extended config overrides basic when selected
// [R21] Converter clock divided to 16 MHz automatically
// [R22] Each peripheral clock enabled by software
// [R23] 30 kHz oscillator usable in deep sleep
// [R24] Cause bits sticky; power-on clears others, sets own
// [R25] External reset spares test port; power-on resets it
// [R26] Reset sources combined, synchronised to system clock
package src_pkg;
   localparam int          ADDR_W          = 6;
   localparam int          DATA_W          = 32;
   localparam int          PER_W           = 96;
   // Register offsets
   localparam logic [5:0]  OFS_BOR_CTL     = 6'h00;
   localparam logic [5:0]  OFS_CAUSE       = 6'h04;
   localparam logic [5:0]  OFS_SRST0       = 6'h08;
   localparam logic [5:0]  OFS_SRST1       = 6'h0C;
   localparam logic [5:0]  OFS_SRST2       = 6'h10;
   localparam logic [5:0]  OFS_CLKGATE0    = 6'h14;
   localparam logic [5:0]  OFS_CLKGATE1    = 6'h18;
   localparam logic [5:0]  OFS_CLKGATE2    = 6'h1C;
   localparam logic [5:0]  OFS_RCC         = 6'h20;
   localparam logic [5:0]  OFS_RCC_EXT     = 6'h24;
   localparam logic [5:0]  OFS_REG_CTL     = 6'h28;
   localparam logic [5:0]  OFS_WDT_LOAD    = 6'h2C;
   localparam logic [5:0]  OFS_WDT_CTL     = 6'h30;
   localparam logic [5:0]  OFS_WDT_VAL     = 6'h34;
   localparam logic [5:0]  OFS_SYS_CTL     = 6'h38;
   localparam logic [5:0]  OFS_DSLP_CFG    = 6'h3C;
   // Field positions
   localparam int          BOR_INT_BIT     = 0;
   localparam int          BOR_RST_EN_BIT  = 1;
   localparam int          CAUSE_EXT_BIT   = 0;
   localparam int          CAUSE_POR_BIT   = 1;
   localparam int          CAUSE_BOR_BIT   = 2;
   localparam int          CAUSE_WDT_BIT   = 3;
   localparam int          CAUSE_SW_BIT    = 4;
   localparam int          RCC_SRC_LSB     = 4;
   localparam int          RCC_DIV_LSB     = 0;
   localparam int          RCC_EXT_SEL_BIT = 31;
   localparam int          WDT_INT_EN_BIT  = 0;
   localparam int          WDT_RST_EN_BIT  = 1;
   localparam int          WDT_INT_CLR_BIT = 2;
   localparam int          SYS_RST_REQ_BIT = 0;
   localparam int          REGULATOR_ADJUST_W          = 6;
   // Reset values
   localparam logic [31:0] BOR_CTL_RST     = 32'h0000_0000;
   localparam logic [31:0] RCC_RST         = 32'h0000_0000;
   localparam logic [31:0] WDT_LOAD_RST    = 32'hFFFF_FFFF;
   localparam logic [5:0]  REGULATOR_ADJUST_RST        = 6'h00;
   localparam logic [4:0]  CAUSE_POR_VAL   = 5'h02;
   // Timing
   localparam int          CLK_KHZ         = 25000;
   localparam int          ADC_KHZ         = 16000;
   localparam int          RST_HOLD_NS     = 160;
   localparam int          RST_HOLD_CYC    = (RST_HOLD_NS * CLK_KHZ + 999_999) / 1_000_000;
   localparam int          ADC_DIV_STEP    = ADC_KHZ;

   typedef enum logic [2:0]
   {
      SRC_INT_OSC,
      SRC_MAIN_OSC,
      SRC_OSC_30K,
      SRC_RT_OSC,
      SRC_PLL,
      SRC_INT_DIV4
   } src_clk_src_t;

   typedef enum logic [1:0]
   {
      SRC_RUN,
      SRC_HOLD,
      SRC_RELEASE
   } src_rst_state_t;
endpackage : src_pkg

/* test/src_system_control_asserts.sv */
// Concurrent checks on the system control block ports
`timescale 1ns/100ps
`default_nettype none
module src_system_control_asserts
(
   input wire logic                      core_clk_i,
   input wire logic                      rst_n_i,
   input wire logic                      ext_rst_n_i,
   input wire logic                      brownout_i,
   input wire logic                      sys_rst_n_o,
   input wire logic                      tap_rst_n_o,
   input wire logic [src_pkg::PER_W-1:0] per_rst_n_o,
   input wire logic                      brownout_irq_o,
   input wire logic [2:0]                clk_src_o,
   input wire logic                      adc_clk_en_o
);
   import src_pkg::*;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence sys_up_s;
      sys_rst_n_o && $past(sys_rst_n_o);
   endsequence

   tap_hold_a: assert property ($past(rst_n_i) |-> tap_rst_n_o)
      else $error("test port reset left power-on only path");
   ext_rst_a: assert property (!ext_rst_n_i |-> ##[1:4] !sys_rst_n_o)
      else $error("external reset did not reach system reset");
   bor_irq_a: assert property (brownout_irq_o |-> $past(brownout_i, 2) || $past(brownout_i, 3))
      else $error("brownout interrupt without detector");
   rst_pulse_a: assert property ($fell(sys_rst_n_o) |=> !sys_rst_n_o [*4])
      else $error("system reset pulse too short");
   per_sysrst_a: assert property (!sys_rst_n_o && !$past(sys_rst_n_o) |-> per_rst_n_o == '0)
      else $error("peripheral resets not held in system reset");
   src_legal_a: assert property (clk_src_o <= 3'h5)
      else $error("illegal clock source code");
   adc_gap_a: assert property (sys_up_s and !adc_clk_en_o |=> adc_clk_en_o)
      else $error("converter enable gap too long");
   soft_pulse_a: assert property (sys_up_s and $fell(per_rst_n_o[3]) |=> per_rst_n_o[3] || !sys_rst_n_o)
      else $error("soft reset pulse longer than one cycle");
endmodule : src_system_control_asserts

bind src_system_control src_system_control_asserts u_asserts
(
   .core_clk_i     (core_clk_i),
   .rst_n_i        (rst_n_i),
   .ext_rst_n_i    (ext_rst_n_i),
   .brownout_i     (brownout_i),
   .sys_rst_n_o    (sys_rst_n_o),
   .tap_rst_n_o    (tap_rst_n_o),
   .per_rst_n_o    (per_rst_n_o),
   .brownout_irq_o (brownout_irq_o),
   .clk_src_o      (clk_src_o),
   .adc_clk_en_o   (adc_clk_en_o)
);
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the system control block
`timescale 1ns/100ps
`default_nettype none
module tb;
   import src_pkg::*;
   logic              clk, rst_n, ext_n, bor, wr, rd, sys_n, tap_n, bor_irq, wdt_irq, adc_en;
   logic [5:0]        addr, div, regulator_adjust;
   logic [31:0]       wdata, rdata;
   logic [PER_W-1:0]  prst_n, pclk;
   logic [2:0]        src, dsrc;
   int                fail_count, compares, cycles;

   src_system_control DUT (.core_clk_i(clk), .rst_n_i(rst_n), .ext_rst_n_i(ext_n), .brownout_i(bor),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sys_rst_n_o(sys_n),
      .tap_rst_n_o(tap_n), .per_rst_n_o(prst_n), .per_clk_en_o(pclk), .brownout_irq_o(bor_irq),
      .wdt_irq_o(wdt_irq), .clk_src_o(src), .sys_div_o(div), .regulator_adjust_o(regulator_adjust),
      .deep_sleep_src_o(dsrc), .adc_clk_en_o(adc_en));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task complete_run;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         complete_run();
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task wr_reg(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      @(negedge clk);
   endtask : wr_reg

   task rd_reg(input logic [5:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask : rd_reg

   // Bounded wait for the system reset level
   task wait_sys(input logic lvl, input int lim);
      for (int i = 0; i < lim && sys_n !== lvl; i++)
         @(negedge clk);
      chk({31'h0, sys_n}, {31'h0, lvl});
   endtask : wait_sys

   task t_bor;
      @(posedge clk);
      bor <= 1'b1;
      repeat (8) @(negedge clk);
      chk({31'h0, bor_irq, sys_n}, 32'h1);
      wr_reg(OFS_BOR_CTL, 32'h1);
      repeat (5) @(negedge clk);
      chk({31'h0, bor_irq, sys_n}, 32'h3);
      wr_reg(OFS_BOR_CTL, 32'h2);
      wait_sys(1'b0, 8);
      repeat (20) @(negedge clk);
      chk({31'h0, sys_n}, 32'h0);
      @(posedge clk);
      bor <= 1'b0;
      wait_sys(1'b1, 30);
      rd_reg(OFS_CAUSE, 32'h6);
      rd_reg(OFS_BOR_CTL, BOR_CTL_RST);
      $display("brownout test done");
   endtask : t_bor

   task t_soft;
      logic seen;
      logic bad;
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(OFS_CLKGATE0 + 6'(4 * i), 32'h1 << (i + 3));
         chk({31'h0, pclk[32 * i + i + 3]}, 32'h1);
         wr_reg(OFS_SRST0 + 6'(4 * i), 32'h1 << (i + 3));
         wr_reg(OFS_SRST0 + 6'(4 * i), 32'h0);
         seen = 1'b0;
         bad  = 1'b0;
         repeat (4)
         begin
            @(negedge clk);
            if (prst_n[32 * i + i + 3] === 1'b0)
               seen = 1'b1;
            if (&(prst_n | ({{(PER_W-1){1'b0}}, 1'b1} << (32 * i + i + 3))) !== 1'b1)
               bad = 1'b1;
         end
         chk({31'h0, seen}, 32'h1);
         chk({31'h0, bad}, 32'h0);
      end
      $display("soft reset test done");
   endtask : t_soft

   task t_sysreq;
      wr_reg(OFS_SYS_CTL, 32'h1 << SYS_RST_REQ_BIT);
      wait_sys(1'b0, 4);
      chk({31'h0, tap_n}, 32'h1);
      wait_sys(1'b1, 30);
      rd_reg(OFS_CAUSE, 32'h16);
      $display("system request test done");
   endtask : t_sysreq

   task t_wdt;
      logic dropped;
      wr_reg(OFS_WDT_LOAD, 32'h8);
      wr_reg(OFS_WDT_CTL, 32'h1);
      for (int i = 0; i < 30 && wdt_irq !== 1'b1; i++)
         @(negedge clk);
      chk({31'h0, wdt_irq}, 32'h1);
      dropped = 1'b0;
      repeat (40)
      begin
         @(negedge clk);
         if (sys_n !== 1'b1)
            dropped = 1'b1;
      end
      chk({31'h0, dropped}, 32'h0);
      wr_reg(OFS_WDT_CTL, 32'h3);
      wait_sys(1'b0, 30);
      wait_sys(1'b1, 30);
      rd_reg(OFS_CAUSE, 32'h1E);
      $display("watchdog test done");
   endtask : t_wdt

   task t_clk;
      int n;
      for (int s = 0; s < 6; s++)
      begin
         wr_reg(OFS_RCC, 32'(s) << RCC_SRC_LSB); // sources modelled as already stable
         chk({29'h0, src}, 32'(s));
      end
      wr_reg(OFS_RCC_EXT, (32'h1 << RCC_EXT_SEL_BIT) | (32'h4 << RCC_SRC_LSB) | 32'h9); // default reference
      chk({29'h0, src}, 32'h4);
      chk({26'h0, div}, 32'h9);
      wr_reg(OFS_RCC_EXT, (32'h1 << RCC_EXT_SEL_BIT) | (32'h6 << RCC_SRC_LSB));
      chk({29'h0, src}, 32'h0);
      wr_reg(OFS_REG_CTL, 32'h2A);
      chk({26'h0, regulator_adjust}, 32'h2A);
      wr_reg(OFS_DSLP_CFG, 32'h2);
      chk({29'h0, dsrc}, 32'h2);
      n = 0;
      repeat (100)
      begin
         @(negedge clk);
         n += int'(adc_en === 1'b1);
      end
      chk(32'(n), 32'd64);
      $display("clock test done");
   endtask : t_clk

   task t_ext;
      @(posedge clk);
      ext_n <= 1'b0;
      repeat (3) @(posedge clk);
      ext_n <= 1'b1;
      wait_sys(1'b0, 4);
      wait_sys(1'b1, 30);
      chk({31'h0, tap_n}, 32'h1);
      rd_reg(OFS_CAUSE, 32'h1F);
      $display("external reset test done");
   endtask : t_ext

   initial
   begin
      rst_n = 1'b0;
      ext_n = 1'b1;
      bor   = 1'b0;
      wr    = 1'b0;
      rd    = 1'b0;
      addr  = 6'h00;
      wdata = 32'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      wait_sys(1'b1, 30);
      chk({29'h0, src}, 32'h0);
      rd_reg(OFS_CAUSE, {27'h0, CAUSE_POR_VAL});
      t_bor();
      t_soft();
      t_sysreq();
      t_wdt();
      t_clk();
      t_ext();
      // Second power-on mid-run: cause back to its own bit only
      @(posedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      chk({30'h0, tap_n, sys_n}, 32'h0);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      wait_sys(1'b1, 30);
      rd_reg(OFS_CAUSE, {27'h0, CAUSE_POR_VAL});
      $display("power-on repeat test done");
      complete_run();
   end
endmodule : tb
`default_nettype wire
